// ### scio_pkg.sv
// package of constants for the system control and parallel port register bank
// assumes an 8-bit internal register bus with address, read and write strobes from the cpu core
package scio_pkg;
    localparam logic [7:0] ADDR_PORT_A  = 8'h00;
    localparam logic [7:0] ADDR_PORT_B  = 8'h01;
    localparam logic [7:0] ADDR_PORT_C  = 8'h02;
    localparam logic [7:0] ADDR_PORT_D  = 8'h03;
    localparam logic [7:0] ADDR_DIR_A   = 8'h04;
    localparam logic [7:0] ADDR_DIR_B   = 8'h05;
    localparam logic [7:0] ADDR_DIR_C   = 8'h06;
    localparam logic [7:0] ADDR_CLKCTL  = 8'h07;
    localparam logic [7:0] ADDR_ADSTAT  = 8'h09;
    localparam logic [7:0] ADDR_MISC    = 8'h0C;
    localparam int BIT_POR     = 7;
    localparam int BIT_IRQ_POS = 6;
    localparam int BIT_IRQ_NEG = 5;
    localparam int BIT_IRQ_EN  = 4;
    localparam int BIT_PWM_A   = 3;
    localparam int BIT_PWM_B   = 2;
    localparam int BIT_SLOW    = 1;
    localparam int BIT_WATCHDOG_ENABLE_KICK    = 0;
    localparam int BIT_CLKOUT  = 3;
    localparam int BIT_CONVERTER_ON    = 5;
    localparam int PIN_CLKOUT  = 2;
    localparam logic [3:0] CLKCTL_LOW_MASK = 4'h7;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [5:0] DIV_FAST = 6'h02;
    localparam logic [5:0] DIV_SLOW = 6'h20;
    localparam logic [12:0] PWM_PERIOD_FAST = 13'h0100;
    localparam logic [12:0] PWM_PERIOD_SLOW = 13'h1000;
    typedef enum logic [1:0] {SCIO_IRQ_LOW_FALL, SCIO_IRQ_FALL, SCIO_IRQ_RISE, SCIO_IRQ_BOTH} scio_irq_mode_e;
endpackage

// ### scio_sync.sv
// two-flop synchroniser for an 8-bit group of pin inputs
// assumes pins are asynchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none
module scio_sync (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic [7:0] pin_in,
    output var  logic [7:0] pin_sync
);
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
    } scio_sync_s;
    scio_sync_s st_q;
    scio_sync_s st_d;
    always_comb begin
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign pin_sync = st_q.s2;
endmodule
`default_nettype wire

// ### scio_bus_clk.sv
// bus clock divider: oscillator over 2 normally, over 32 in slow mode
// assumes clk_sys is the oscillator; emits a one-cycle bus tick and a clock level
`timescale 1ns/100ps
`default_nettype none
module scio_bus_clk (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic slow_bus_mode,
    output var  logic bus_tick,
    output var  logic bus_clk
);
    typedef struct packed {
        logic [5:0] cnt;
        logic       tick;
        logic       clk;
    } scio_div_s;
    scio_div_s st_q;
    scio_div_s st_d;
    logic [5:0] div;
    always_comb begin
        div = slow_bus_mode ? scio_pkg::DIV_SLOW : scio_pkg::DIV_FAST;
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt >= div - 6'h01) begin
            st_d.cnt = 6'h00;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 6'h01;
        end
        st_d.clk = (st_d.cnt < (div >> 1)) ? 1'b1 : 1'b0;
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign bus_tick = st_q.tick;
    assign bus_clk  = st_q.clk;
endmodule
`default_nettype wire

// ### scio_top.sv
// system control register and parallel ports a-d
// assumes cpu core drives addr, wr_en, wr_data, rd_en on clk_sys; rd_data valid the cycle after rd_en
`timescale 1ns/100ps
`default_nettype none
module scio_top #(
    parameter logic WATCHDOG_ENABLE_KICK_FACTORY_ON = 1'b1
) (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       por_event,
    input  wire logic       cpu_irq_mask,
    input  wire logic       stop_entry,
    input  wire logic [7:0] addr,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    input  wire logic [7:0] port_a_in,
    output logic      [7:0] port_a_out,
    output logic      [7:0] port_a_oe,
    input  wire logic [7:0] port_b_in,
    output logic      [7:0] port_b_out,
    output logic      [7:0] port_b_oe,
    input  wire logic [7:0] port_c_in,
    output logic      [7:0] port_c_out,
    output logic      [7:0] port_c_oe,
    input  wire logic [7:0] port_d_pins,
    output logic            converter_on,
    output logic      [1:0] irq_mode,
    output logic            external_interrupt_enable,
    output logic            pwm_a_rate_select,
    output logic            pwm_b_rate_select,
    output logic     [12:0] pwm_a_period,
    output logic     [12:0] pwm_b_period,
    output logic            slow_bus_mode,
    output logic            bus_tick,
    output logic            watchdog_enable,
    output logic            watchdog_kick
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  lat_a;
        logic [7:0]  lat_b;
        logic [7:0]  lat_c;
        logic [7:0]  dir_a;
        logic [7:0]  dir_b;
        logic [7:0]  dir_c;
        logic        por_flag;
        logic        irq_positive_select;
        logic        irq_negative_select;
        logic        external_interrupt_enable;
        logic        pwm_a_rate_select;
        logic        pwm_b_rate_select;
        logic        slow_bus_mode;
        logic        watchdog_enable_kick;
        logic        kick;
        logic        clock_output_enable;
        logic [2:0]  clkctl_low;
        logic        converter_on;
        logic [7:0]  rd_data;
        logic [12:0] per_a;
        logic [12:0] per_b;
        logic [7:0]  out_c;
        logic [7:0]  oe_c;
    } scio_top_s;
    scio_top_s st_q;
    scio_top_s st_d;

    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] sync_c;
    logic [7:0] sync_d;
    logic       bus_clk;
    logic       bus_tick_w;
    logic [7:0] eff_dir_c;

    // ****************************************************************
    // pin synchronisers and bus clock
    // ****************************************************************
    scio_sync u_sync_a (.clk_sys(clk_sys), .nrst(nrst), .pin_in(port_a_in), .pin_sync(sync_a));
    scio_sync u_sync_b (.clk_sys(clk_sys), .nrst(nrst), .pin_in(port_b_in), .pin_sync(sync_b));
    scio_sync u_sync_c (.clk_sys(clk_sys), .nrst(nrst), .pin_in(port_c_in), .pin_sync(sync_c));
    scio_sync u_sync_d (.clk_sys(clk_sys), .nrst(nrst), .pin_in(port_d_pins), .pin_sync(sync_d));
    scio_bus_clk u_bus_clk (
        .clk_sys       (clk_sys),
        .nrst          (nrst),
        .slow_bus_mode (st_q.slow_bus_mode),
        .bus_tick      (bus_tick_w),
        .bus_clk       (bus_clk)
    );

    function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] pin);
        port_read = (dir & lat) | (~dir & pin);
    endfunction

    function automatic logic [12:0] pwm_period(input logic slow);
        pwm_period = slow ? scio_pkg::PWM_PERIOD_SLOW : scio_pkg::PWM_PERIOD_FAST;
    endfunction

    // ****************************************************************
    // register bank
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        st_d.kick = 1'b0;
        eff_dir_c = st_q.dir_c;
        if (st_q.clock_output_enable) begin
            eff_dir_c[scio_pkg::PIN_CLKOUT] = 1'b1;
        end
        if (stop_entry) begin
            st_d.slow_bus_mode = 1'b0;
        end
        if (wr_en) begin
            unique case (addr)
                scio_pkg::ADDR_PORT_A: st_d.lat_a = wr_data;
                scio_pkg::ADDR_PORT_B: st_d.lat_b = wr_data;
                scio_pkg::ADDR_PORT_C: st_d.lat_c = wr_data;
                scio_pkg::ADDR_DIR_A:  st_d.dir_a = wr_data;
                scio_pkg::ADDR_DIR_B:  st_d.dir_b = wr_data;
                scio_pkg::ADDR_DIR_C:  st_d.dir_c = wr_data;
                scio_pkg::ADDR_CLKCTL: begin
                    st_d.clock_output_enable = wr_data[scio_pkg::BIT_CLKOUT];
                    st_d.clkctl_low = wr_data[2:0] & scio_pkg::CLKCTL_LOW_MASK[2:0];
                end
                scio_pkg::ADDR_ADSTAT: st_d.converter_on = wr_data[scio_pkg::BIT_CONVERTER_ON];
                scio_pkg::ADDR_MISC: begin
                    if (!wr_data[scio_pkg::BIT_POR]) begin
                        st_d.por_flag = 1'b0;
                    end
                    if (cpu_irq_mask) begin
                        st_d.irq_positive_select = wr_data[scio_pkg::BIT_IRQ_POS];
                        st_d.irq_negative_select = wr_data[scio_pkg::BIT_IRQ_NEG];
                        st_d.external_interrupt_enable = wr_data[scio_pkg::BIT_IRQ_EN];
                    end
                    st_d.pwm_a_rate_select = wr_data[scio_pkg::BIT_PWM_A];
                    st_d.pwm_b_rate_select = wr_data[scio_pkg::BIT_PWM_B];
                    if (!stop_entry) begin
                        st_d.slow_bus_mode = wr_data[scio_pkg::BIT_SLOW];
                    end
                    if (wr_data[scio_pkg::BIT_WATCHDOG_ENABLE_KICK]) begin
                        st_d.watchdog_enable_kick = 1'b1;
                        st_d.kick = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (por_event) begin
            st_d.por_flag = 1'b1;
        end
        st_d.rd_data = 8'h00;
        if (rd_en) begin
            unique case (addr)
                scio_pkg::ADDR_PORT_A: st_d.rd_data = port_read(st_q.dir_a, st_q.lat_a, sync_a);
                scio_pkg::ADDR_PORT_B: st_d.rd_data = port_read(st_q.dir_b, st_q.lat_b, sync_b);
                scio_pkg::ADDR_PORT_C: st_d.rd_data = port_read(eff_dir_c, st_q.lat_c, sync_c);
                scio_pkg::ADDR_PORT_D: st_d.rd_data = st_q.converter_on ? 8'h00 : sync_d;
                scio_pkg::ADDR_DIR_A:  st_d.rd_data = st_q.dir_a;
                scio_pkg::ADDR_DIR_B:  st_d.rd_data = st_q.dir_b;
                scio_pkg::ADDR_DIR_C:  st_d.rd_data = eff_dir_c;
                scio_pkg::ADDR_CLKCTL: st_d.rd_data = {4'h0, st_q.clock_output_enable, st_q.clkctl_low};
                scio_pkg::ADDR_ADSTAT: st_d.rd_data = {2'h0, st_q.converter_on, 5'h00};
                scio_pkg::ADDR_MISC:   st_d.rd_data = {st_q.por_flag, st_q.irq_positive_select,
                                                       st_q.irq_negative_select, st_q.external_interrupt_enable,
                                                       st_q.pwm_a_rate_select, st_q.pwm_b_rate_select,
                                                       st_q.slow_bus_mode, st_q.watchdog_enable_kick};
                default:               st_d.rd_data = 8'h00;
            endcase
        end
        st_d.per_a = pwm_period(st_d.pwm_a_rate_select);
        st_d.per_b = pwm_period(st_d.pwm_b_rate_select);
        st_d.oe_c = st_d.dir_c;
        if (st_d.clock_output_enable) begin
            st_d.oe_c[scio_pkg::PIN_CLKOUT] = 1'b1;
        end
        st_d.out_c = st_d.lat_c;
        if (st_d.clock_output_enable) begin
            st_d.out_c[scio_pkg::PIN_CLKOUT] = bus_clk;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_q.dir_a <= scio_pkg::DIR_RESET;
            st_q.dir_b <= scio_pkg::DIR_RESET;
            st_q.dir_c <= scio_pkg::DIR_RESET;
            st_q.irq_positive_select <= 1'b0;
            st_q.irq_negative_select <= 1'b0;
            st_q.external_interrupt_enable <= 1'b1;
            st_q.slow_bus_mode <= 1'b0;
            st_q.watchdog_enable_kick <= WATCHDOG_ENABLE_KICK_FACTORY_ON;
            st_q.kick <= 1'b0;
            st_q.clock_output_enable <= 1'b0;
            st_q.clkctl_low <= 3'h0;
            st_q.converter_on <= 1'b0;
            st_q.rd_data <= 8'h00;
            st_q.oe_c <= scio_pkg::DIR_RESET;
            st_q.per_a <= scio_pkg::PWM_PERIOD_FAST;
            st_q.per_b <= scio_pkg::PWM_PERIOD_FAST;
            st_q.por_flag <= st_d.por_flag;
            st_q.pwm_a_rate_select <= 1'b0;
            st_q.pwm_b_rate_select <= 1'b0;
            st_q.lat_a <= st_q.lat_a;
            st_q.lat_b <= st_q.lat_b;
            st_q.lat_c <= st_q.lat_c;
            st_q.out_c <= st_q.lat_c;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign rd_data    = st_q.rd_data;
    assign port_a_out = st_q.lat_a;
    assign port_a_oe  = st_q.dir_a;
    assign port_b_out = st_q.lat_b;
    assign port_b_oe  = st_q.dir_b;
    assign port_c_oe  = st_q.oe_c;
    assign port_c_out = st_q.out_c;
    assign converter_on              = st_q.converter_on;
    assign irq_mode                  = {st_q.irq_positive_select, st_q.irq_negative_select};
    assign external_interrupt_enable = st_q.external_interrupt_enable;
    assign pwm_a_rate_select         = st_q.pwm_a_rate_select;
    assign pwm_b_rate_select         = st_q.pwm_b_rate_select;
    assign pwm_a_period              = st_q.per_a;
    assign pwm_b_period              = st_q.per_b;
    assign slow_bus_mode             = st_q.slow_bus_mode;
    assign bus_tick                  = bus_tick_w;
    assign watchdog_enable           = st_q.watchdog_enable_kick;
    assign watchdog_kick             = st_q.kick;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_por_set;
        @(posedge clk_sys) por_event |=> st_q.por_flag;
    endproperty
    a_por_set: assert property (p_por_set) else $error("power-on flag not set");
    property p_por_no_sw_set;
        @(posedge clk_sys) disable iff (!nrst) (!st_q.por_flag && !por_event) |=> !st_q.por_flag;
    endproperty
    a_por_no_sw_set: assert property (p_por_no_sw_set) else $error("power-on flag set by software");
    property p_irq_locked;
        @(posedge clk_sys) disable iff (!nrst) !cpu_irq_mask |=> $stable(irq_mode) && $stable(st_q.external_interrupt_enable);
    endproperty
    a_irq_locked: assert property (p_irq_locked) else $error("interrupt bits changed with mask clear");
    property p_stop_slow;
        @(posedge clk_sys) disable iff (!nrst) stop_entry |=> !st_q.slow_bus_mode;
    endproperty
    a_stop_slow: assert property (p_stop_slow) else $error("slow mode survived stop");
    property p_watchdog_enable_kick_sticky;
        @(posedge clk_sys) disable iff (!nrst) st_q.watchdog_enable_kick |=> st_q.watchdog_enable_kick;
    endproperty
    a_watchdog_enable_kick_sticky: assert property (p_watchdog_enable_kick_sticky) else $error("watchdog disabled");
    property p_clkout_oe;
        @(posedge clk_sys) disable iff (!nrst) st_q.clock_output_enable |-> port_c_oe[scio_pkg::PIN_CLKOUT];
    endproperty
    a_clkout_oe: assert property (p_clkout_oe) else $error("clock pin not driven");
    property p_period;
        @(posedge clk_sys) disable iff (!nrst)
            pwm_a_period == (st_q.pwm_a_rate_select ? scio_pkg::PWM_PERIOD_SLOW : scio_pkg::PWM_PERIOD_FAST);
    endproperty
    a_period: assert property (p_period) else $error("pwm period wrong");
    property p_oe_a;
        @(posedge clk_sys) disable iff (!nrst) (wr_en && addr == scio_pkg::ADDR_DIR_A) |=> port_a_oe == $past(wr_data);
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("direction write lost");
    property p_period_b;
        @(posedge clk_sys) disable iff (!nrst)
            pwm_b_period == (st_q.pwm_b_rate_select ? scio_pkg::PWM_PERIOD_SLOW : scio_pkg::PWM_PERIOD_FAST);
    endproperty
    a_period_b: assert property (p_period_b) else $error("pwm b period wrong");
    property p_reset_state;
        @(posedge clk_sys) !nrst |=> external_interrupt_enable && (irq_mode == 2'b00) && !slow_bus_mode
            && !converter_on && (port_a_oe == scio_pkg::DIR_RESET) && !st_q.clock_output_enable;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
    property p_latch_b;
        @(posedge clk_sys) disable iff (!nrst)
            (wr_en && addr == scio_pkg::ADDR_PORT_B) |=> port_b_out == $past(wr_data);
    endproperty
    a_latch_b: assert property (p_latch_b) else $error("port latch write lost");
    property p_dir_read;
        @(posedge clk_sys) disable iff (!nrst)
            (rd_en && addr == scio_pkg::ADDR_DIR_B) |=> rd_data == $past(st_q.dir_b);
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read wrong");
    property p_clkout_read;
        @(posedge clk_sys) disable iff (!nrst) (rd_en && addr == scio_pkg::ADDR_PORT_C && st_q.clock_output_enable)
            |=> rd_data[scio_pkg::PIN_CLKOUT] == $past(st_q.lat_c[scio_pkg::PIN_CLKOUT]);
    endproperty
    a_clkout_read: assert property (p_clkout_read) else $error("clock pin read not latch");
    property p_clkctl_upper;
        @(posedge clk_sys) disable iff (!nrst)
            (rd_en && addr == scio_pkg::ADDR_CLKCTL) |=> rd_data[7:4] == 4'h0;
    endproperty
    a_clkctl_upper: assert property (p_clkctl_upper) else $error("clock control upper bits set");
    property p_port_d_analog;
        @(posedge clk_sys) disable iff (!nrst)
            (rd_en && addr == scio_pkg::ADDR_PORT_D && st_q.converter_on) |=> rd_data == 8'h00;
    endproperty
    a_port_d_analog: assert property (p_port_d_analog) else $error("analog port read digital");
endmodule
`default_nettype wire

// ### scio_cpu_model.sv
// cpu core model: issues register bus writes and reads
// assumes the block samples the bus on rising clk_sys; requests change at falling edges
`timescale 1ns/100ps
`default_nettype none
module scio_cpu_model (
    input  wire logic       clk_sys,
    output var  logic [7:0] addr,
    output var  logic       wr_en,
    output var  logic [7:0] wr_data,
    output var  logic       rd_en
);
    initial begin
        addr = 8'h00;
        wr_en = 1'b0;
        wr_data = 8'h00;
        rd_en = 1'b0;
    end
    // one request per call, held across exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge clk_sys);
        wr_en = 1'b0;
        wr_data = ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk_sys);
        rd_en = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### scio_top_bench.sv
// self-checking bench for the system control register and ports
// assumes scio_top and the cpu model; reads checked from a queue of expected values
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t %s", $time, m); end end
module scio_top_bench;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        por_event = 1'b1;
    logic        cpu_irq_mask = 1'b0;
    logic        stop_entry = 1'b0;
    logic [7:0]  port_a_in = 8'h00, port_b_in = 8'h00, port_c_in = 8'h00, port_d_pins = 8'h00;
    logic [7:0]  addr, wr_data, rd_data, port_a_out, port_a_oe, port_b_out, port_b_oe, port_c_out, port_c_oe;
    logic        wr_en, rd_en, converter_on, external_interrupt_enable, pwm_a_rate_select, pwm_b_rate_select;
    logic        slow_bus_mode, bus_tick, watchdog_enable, watchdog_kick;
    logic [1:0]  irq_mode;
    logic [12:0] pwm_a_period, pwm_b_period;
    logic [31:0] rnd = 32'hF3D1;
    logic [15:0] expq[$];
    logic [15:0] ent;
    logic [7:0]  la;
    logic        taken = 1'b0;
    logic        seen0, seen1;
    int          n_fail = 0, compares = 0, kicks = 0, n;
    wire  [23:0] all_out = {port_c_out, port_b_out, port_a_out};
    wire  [23:0] all_oe = {port_c_oe, port_b_oe, port_a_oe};
    wire  [23:0] all_in = {port_c_in, port_b_in, port_a_in};

    always #12.5 clk_sys = ~clk_sys;

    scio_cpu_model cpu_inst (.clk_sys(clk_sys), .addr(addr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));
    scio_top #(.WATCHDOG_ENABLE_KICK_FACTORY_ON(1'b0)) scio_top_inst (.clk_sys(clk_sys), .nrst(nrst), .por_event(por_event),
        .cpu_irq_mask(cpu_irq_mask), .stop_entry(stop_entry), .addr(addr), .wr_en(wr_en), .wr_data(wr_data),
        .rd_en(rd_en), .rd_data(rd_data), .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
        .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe), .port_c_in(port_c_in),
        .port_c_out(port_c_out), .port_c_oe(port_c_oe), .port_d_pins(port_d_pins), .converter_on(converter_on),
        .irq_mode(irq_mode), .external_interrupt_enable(external_interrupt_enable),
        .pwm_a_rate_select(pwm_a_rate_select), .pwm_b_rate_select(pwm_b_rate_select),
        .pwm_a_period(pwm_a_period), .pwm_b_period(pwm_b_period), .slow_bus_mode(slow_bus_mode),
        .bus_tick(bus_tick), .watchdog_enable(watchdog_enable), .watchdog_kick(watchdog_kick));

    // ****************************************
    // read checker and helpers
    // ****************************************
    always @(posedge clk_sys) begin
        taken <= rd_en;
        if (watchdog_kick === 1'b1) kicks <= kicks + 1;
    end
    always @(negedge clk_sys) begin
        if (taken) begin
            `CHK(expq.size() != 0, 1'b1, "read with no expected value")
            ent = (expq.size() > 0) ? expq.pop_front() : 16'h0000;
            `CHK(rd_data & ent[7:0], ent[15:8] & ent[7:0], "read data mismatch")
        end
    end
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        expq.push_back({e, m});
        cpu_inst.rd(a);
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic do_reset(input logic por);
        nrst = 1'b0;
        por_event = por;
        repeat (5) @(negedge clk_sys);
        nrst = 1'b1;
        por_event = 1'b0;
    endtask
    task automatic tick_gap(output int g);
        int k;
        k = 0;
        while (bus_tick !== 1'b1 && k < 100) begin
            @(negedge clk_sys);
            k++;
        end
        g = 0;
        do begin
            @(negedge clk_sys);
            g++;
        end while (bus_tick !== 1'b1 && g < 100);
    endtask
    task automatic print_verdict;
        $display("counts: %0d compares, %0d failures", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #(20000 * 25);
        n_fail++;
        $display("[FAIL] %0t watchdog timeout", $time);
        print_verdict;
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        do_reset(1'b1);
        rd(scio_pkg::ADDR_MISC, 8'h90, 8'hFF);
        for (int i = 4; i < 7; i++) rd(i[7:0], 8'h00, 8'hFF);
        rd(scio_pkg::ADDR_CLKCTL, 8'h00, 8'hF8);
        `CHK({all_oe, converter_on}, 25'h0, "reset outputs")
        `CHK({irq_mode, external_interrupt_enable, slow_bus_mode, watchdog_enable}, 5'b00100, "reset misc")
        $display("reset test done");
        cpu_inst.wr(scio_pkg::ADDR_MISC, 8'h10);
        rd(scio_pkg::ADDR_MISC, 8'h10, 8'hF3);
        cpu_inst.wr(scio_pkg::ADDR_MISC, 8'h90);
        rd(scio_pkg::ADDR_MISC, 8'h10, 8'hF3);
        cpu_inst.wr(scio_pkg::ADDR_MISC, 8'h60);
        `CHK({irq_mode, external_interrupt_enable}, 3'b001, "irq bits written while unmasked")
        cpu_irq_mask = 1'b1;
        for (int m = 0; m < 4; m++) begin
            cpu_inst.wr(scio_pkg::ADDR_MISC, {1'b0, m[1:0], 5'h00});
            `CHK({irq_mode, external_interrupt_enable}, {m[1:0], 1'b0}, "irq mode")
            rd(scio_pkg::ADDR_MISC, {1'b0, m[1:0], 5'h00}, 8'hFF);
        end
        $display("power-on flag and irq test done");
        // rate selects programmed and both pwm periods checked
        for (int i = 0; i < 4; i++) begin
            cpu_inst.wr(scio_pkg::ADDR_MISC, {4'h1, i[1:0], 2'b00});
            `CHK({pwm_a_rate_select, pwm_b_rate_select}, i[1:0], "pwm rate bits")
            `CHK({pwm_a_period, pwm_b_period}, {i[1] ? 13'h1000 : 13'h0100, i[0] ? 13'h1000 : 13'h0100}, "pwm")
        end
        cpu_inst.wr(scio_pkg::ADDR_MISC, 8'h12);
        tick_gap(n);
        tick_gap(n);
        `CHK(n, 32, "slow bus tick spacing")
        @(negedge clk_sys) stop_entry = 1'b1;
        @(negedge clk_sys) stop_entry = 1'b0;
        @(negedge clk_sys);
        `CHK(slow_bus_mode, 1'b0, "stop entry leaves slow mode")
        tick_gap(n);
        tick_gap(n);
        `CHK(n, 2, "fast bus tick spacing")
        cpu_inst.wr(scio_pkg::ADDR_MISC, 8'h11);
        cpu_inst.wr(scio_pkg::ADDR_MISC, 8'h10);
        repeat (3) @(negedge clk_sys);
        `CHK({watchdog_enable, kicks}, {1'b1, 32'd1}, "watchdog enable and single kick")
        $display("pwm, slow mode and watchdog test done");
        rnd = lfsr(rnd);
        {port_d_pins, port_c_in, port_b_in, port_a_in} = rnd;
        for (int p = 0; p < 3; p++) begin
            rnd = lfsr(rnd);
            cpu_inst.wr(p[7:0], rnd[7:0]);
            cpu_inst.wr(p[7:0] + 8'h04, rnd[15:8]);
            `CHK({all_out[p*8+:8], all_oe[p*8+:8]}, {rnd[7:0], rnd[15:8]}, "port latch and drive")
            rd(p[7:0] + 8'h04, rnd[15:8], 8'hFF);
            rd(p[7:0], (rnd[7:0] & rnd[15:8]) | (all_in[p*8+:8] & ~rnd[15:8]), 8'hFF);
        end
        rd(scio_pkg::ADDR_PORT_D, port_d_pins, 8'hFF);
        cpu_inst.wr(scio_pkg::ADDR_ADSTAT, 8'h20);
        `CHK(converter_on, 1'b1, "converter on")
        rd(scio_pkg::ADDR_PORT_D, 8'h00, 8'hFF);
        rd(8'h20, 8'h00, 8'hFF);
        $display("port test done");
        port_c_in = 8'h00;
        cpu_inst.wr(scio_pkg::ADDR_DIR_C, 8'h00);
        cpu_inst.wr(scio_pkg::ADDR_PORT_C, 8'h04);
        cpu_inst.wr(scio_pkg::ADDR_CLKCTL, 8'hFD);
        rd(scio_pkg::ADDR_CLKCTL, 8'h0D, 8'hFF);
        rd(scio_pkg::ADDR_PORT_C, 8'h04, 8'hFF);
        `CHK(port_c_oe, 8'h04, "clock output drive")
        seen0 = 1'b0;
        seen1 = 1'b0;
        repeat (8) begin
            @(negedge clk_sys);
            seen0 = seen0 | (port_c_out[2] === 1'b0);
            seen1 = seen1 | (port_c_out[2] === 1'b1);
        end
        `CHK({seen1, seen0}, 2'b11, "clock output toggles")
        la = port_a_out;
        do_reset(1'b0);
        @(negedge clk_sys);
        `CHK({port_a_out, all_oe, converter_on}, {la, 25'h0}, "external reset state")
        rd(scio_pkg::ADDR_MISC, 8'h10, 8'hFF);
        rd(scio_pkg::ADDR_CLKCTL, 8'h00, 8'hF8);
        repeat (4) @(negedge clk_sys);
        $display("clock output and external reset test done");
        print_verdict;
    end
endmodule
`default_nettype wire
